//--- core/stl_pkg.sv
// Package for the stop trip latch logic: modes and reset values.
// Assumes one clock domain; all inputs are plain level signals.
package stl_pkg;

    // Stop behaviour setting for each of the three stop sources.
    typedef enum logic {
        STL_UNLATCHED = 1'b0,
        STL_LATCHED = 1'b1
    } stl_mode_t;

    // Value of every trip flag after reset.
    localparam logic STL_TRIP_RST = 1'b0;
    // Value of the run command after reset.
    localparam logic STL_RUN_RST = 1'b0;
    // Value of the dropout notice after reset.
    localparam logic STL_NOTICE_RST = 1'b0;
    // Depth of the input synchronisers.
    localparam int STL_SYNC_DEPTH = 2;
    // Synchroniser value after reset, one bit per pin, from the top: start
    // request, process contact, reset key, stop key, contactor B and A.
    // Contactors and the process contact rest closed, so leaving reset
    // never looks like a dropout or a contact opening.
    localparam logic [5:0] STL_SYNC_RST = 6'h13;

endpackage

//--- core/stl_stop_trip_latch.sv
// Stop trip latch: turns stop sources into trips, run command and notices.
// Assumes pin inputs are asynchronous and settings come from this domain.
//
// Function
// - Three stop sources, each latched or unlatched.
// - Unlatched dropout only raises the dropout notice.
// - Latched dropout raises an emergency stop trip.
// - Emergency trip blocks starting until reset.
// - Latched panel stop key trips; reset clears.
// - Latched process contact opening trips; reset clears.
// - Held start restarts at once upon reset.
`timescale 1ns/10ps
module stl_stop_trip_latch (
    input wire logic mclk_in, // System clock, 250 MHz.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire stl_pkg::stl_mode_t contactor_stop_mode_in, // Dropout mode.
    input wire stl_pkg::stl_mode_t front_panel_key_stop_mode_in, // Key mode.
    input wire stl_pkg::stl_mode_t process_stop_mode_in, // Contact mode.
    input wire logic contactor_a_closed_in, // Contactor A status pin.
    input wire logic contactor_b_closed_in, // Contactor B status pin.
    input wire logic stop_key_in, // Panel stop key, high when pressed.
    input wire logic reset_key_in, // Reset key, high when pressed.
    input wire logic process_contact_closed_in, // Stop contact, high closed.
    input wire logic start_req_in, // Start request, high while held.
    output logic run_out, // Start drive, high to run the motor.
    output logic stop_cmd_out, // Stop drive, high while stopped.
    output logic dropout_notice_out, // External stop notice.
    output logic emergency_trip_out, // Contactor dropout trip.
    output logic key_trip_out, // Latched panel stop trip.
    output logic process_trip_out // Latched process stop trip.
);
    import stl_pkg::*;

    // Number of synchronised pin inputs.
    localparam int NIN = 6;

    // Raw pin vector and its synchronised copy, taken from the second stage.
    logic [NIN-1:0] pins_raw;
    logic [NIN-1:0] sync_q;

    assign pins_raw = {start_req_in, process_contact_closed_in,
                       reset_key_in, stop_key_in,
                       contactor_b_closed_in, contactor_a_closed_in};

    // Two flip-flops per pin; only the second stage is read by logic.
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            logic s1_ff;
            logic s2_ff;
            // Synchroniser chain for one pin. It resets to the pin's rest
            // level, so a closed contact does not read open after reset.
            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    s1_ff <= STL_SYNC_RST[gi];
                    s2_ff <= STL_SYNC_RST[gi];
                end else begin
                    s1_ff <= pins_raw[gi];
                    s2_ff <= s1_ff;
                end
            end
            assign sync_q[gi] = s2_ff;
        end
    endgenerate

    // Named views of the synchronised pins.
    wire ca_s = sync_q[0];
    wire cb_s = sync_q[1];
    wire stop_s = sync_q[2];
    wire rst_key_s = sync_q[3];
    wire proc_s = sync_q[4];
    wire start_s = sync_q[5];

    // State registers.
    logic run_ff;
    logic notice_ff;
    logic etrip_ff;
    logic ktrip_ff;
    logic ptrip_ff;

    // Contactor dropout while running means the stop came from outside.
    wire ext_stop = run_ff & ~(ca_s & cb_s);
    // Stop sources as seen this cycle.
    wire key_stop = stop_s;
    wire proc_stop = ~proc_s;
    // Mode decodes, one per source, high when the source is latched.
    wire cm_lat = (contactor_stop_mode_in == STL_LATCHED);
    wire km_lat = (front_panel_key_stop_mode_in == STL_LATCHED);
    wire pm_lat = (process_stop_mode_in == STL_LATCHED);
    // Latched events raise trips; the mode decides per source.
    wire set_etrip = ext_stop & cm_lat;
    wire set_ktrip = key_stop & km_lat;
    wire set_ptrip = proc_stop & pm_lat;
    wire set_notice = ext_stop & ~cm_lat;

    // Next trip values: a new event wins over the reset key.
    wire nxt_etrip = set_etrip | (etrip_ff & ~rst_key_s);
    wire nxt_ktrip = set_ktrip | (ktrip_ff & ~rst_key_s);
    wire nxt_ptrip = set_ptrip | (ptrip_ff & ~rst_key_s);
    wire any_trip = nxt_etrip | nxt_ktrip | nxt_ptrip;
    // Any stop this cycle, latched or not, stops the motor.
    wire any_stop = ext_stop | key_stop | proc_stop;
    // A held start runs as soon as no trip remains after reset.
    wire nxt_run = start_s & ~any_trip & ~any_stop
                   | run_ff & ~any_trip & ~any_stop;
    // Notice clears on reset key or a fresh start.
    wire nxt_notice = set_notice | (notice_ff & ~rst_key_s & ~nxt_run);

    // Trip and run state registers.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            run_ff <= STL_RUN_RST;
            notice_ff <= STL_NOTICE_RST;
            etrip_ff <= STL_TRIP_RST;
            ktrip_ff <= STL_TRIP_RST;
            ptrip_ff <= STL_TRIP_RST;
        end else begin
            run_ff <= nxt_run;
            notice_ff <= nxt_notice;
            etrip_ff <= nxt_etrip;
            ktrip_ff <= nxt_ktrip;
            ptrip_ff <= nxt_ptrip;
        end
    end

    // Outputs come straight from the state registers.
    assign run_out = run_ff;
    assign stop_cmd_out = ~run_ff;
    assign dropout_notice_out = notice_ff;
    assign emergency_trip_out = etrip_ff;
    assign key_trip_out = ktrip_ff;
    assign process_trip_out = ptrip_ff;

    // Checks on the trip and run behaviour.
    property p_trip_blocks_run;
        @(posedge mclk_in) disable iff (rst_in)
        (etrip_ff | ktrip_ff | ptrip_ff) |-> !run_ff;
    endproperty
    a_trip_blocks_run: assert property (p_trip_blocks_run)
        else $error("Motor runs while a trip is set.");

    property p_latched_dropout_trips;
        @(posedge mclk_in) disable iff (rst_in)
        (run_ff && !(ca_s && cb_s)
         && contactor_stop_mode_in == STL_LATCHED) |=> etrip_ff;
    endproperty
    a_latched_dropout_trips: assert property
        (p_latched_dropout_trips)
        else $error("Latched dropout did not trip.");

    property p_unlatched_dropout_notice;
        @(posedge mclk_in) disable iff (rst_in)
        (run_ff && !(ca_s && cb_s)
         && contactor_stop_mode_in == STL_UNLATCHED)
        |=> notice_ff && !run_ff && !$rose(etrip_ff);
    endproperty
    a_unlatched_dropout_notice: assert property
        (p_unlatched_dropout_notice)
        else $error("Unlatched dropout handled wrongly.");

    property p_key_trip;
        @(posedge mclk_in) disable iff (rst_in)
        (stop_s && front_panel_key_stop_mode_in == STL_LATCHED)
        |=> ktrip_ff && !run_ff;
    endproperty
    a_key_trip: assert property (p_key_trip)
        else $error("Latched key stop did not trip.");

    property p_process_trip;
        @(posedge mclk_in) disable iff (rst_in)
        (!proc_s && process_stop_mode_in == STL_LATCHED) |=> ptrip_ff;
    endproperty
    a_process_trip: assert property (p_process_trip)
        else $error("Process contact opening did not trip.");

    property p_held_start_restarts;
        @(posedge mclk_in) disable iff (rst_in)
        (ktrip_ff && rst_key_s && start_s && !stop_s && proc_s
         && !etrip_ff && !ptrip_ff) |=> run_ff;
    endproperty
    a_held_start_restarts: assert property (p_held_start_restarts)
        else $error("Held start did not restart on reset.");

    property p_unlatched_key_no_trip;
        @(posedge mclk_in) disable iff (rst_in)
        (stop_s && front_panel_key_stop_mode_in == STL_UNLATCHED
         && !ktrip_ff) |=> !ktrip_ff && !run_ff;
    endproperty
    a_unlatched_key_no_trip: assert property
        (p_unlatched_key_no_trip)
        else $error("Unlatched key stop set a trip.");

    property p_trip_holds;
        @(posedge mclk_in) disable iff (rst_in)
        (etrip_ff && !rst_key_s) |=> etrip_ff;
    endproperty
    a_trip_holds: assert property (p_trip_holds)
        else $error("Trip cleared without reset key.");

    // A dropout seen while stopped must never raise the emergency trip.
    property p_dropout_needs_run;
        @(posedge mclk_in) disable iff (rst_in)
        (!run_ff && !etrip_ff) |=> !etrip_ff;
    endproperty
    a_dropout_needs_run: assert property (p_dropout_needs_run)
        else $error("Dropout trip without running motor.");

    // An unlatched process stop stops the motor and leaves no trip.
    property p_unlatched_proc_no_trip;
        @(posedge mclk_in) disable iff (rst_in)
        (!proc_s && process_stop_mode_in == STL_UNLATCHED
         && !ptrip_ff) |=> !ptrip_ff && !run_ff;
    endproperty
    a_unlatched_proc_no_trip: assert property
        (p_unlatched_proc_no_trip)
        else $error("Unlatched process stop set a trip.");

    // The key trip stays set until the reset key is seen.
    property p_key_trip_holds;
        @(posedge mclk_in) disable iff (rst_in)
        (ktrip_ff && !rst_key_s) |=> ktrip_ff;
    endproperty
    a_key_trip_holds: assert property (p_key_trip_holds)
        else $error("Key trip cleared without reset key.");

    // The process trip stays set until the reset key is seen.
    property p_process_trip_holds;
        @(posedge mclk_in) disable iff (rst_in)
        (ptrip_ff && !rst_key_s) |=> ptrip_ff;
    endproperty
    a_process_trip_holds: assert property (p_process_trip_holds)
        else $error("Process trip cleared without reset key.");

    // A latched dropout setting never raises the dropout notice.
    property p_latched_no_notice;
        @(posedge mclk_in) disable iff (rst_in)
        (contactor_stop_mode_in == STL_LATCHED) |=> !$rose(notice_ff);
    endproperty
    a_latched_no_notice: assert property (p_latched_no_notice)
        else $error("Latched dropout raised the notice.");

endmodule

//--- bench/stl_field_model.sv
// Field side model: two contactors and the process stop contact.
// Assumes the bench commands every dropout and contact opening.
`timescale 1ns/10ps
module stl_field_model (
    input wire logic drop_a_in, // Open contactor A.
    input wire logic drop_b_in, // Open contactor B.
    input wire logic open_in, // Open the process stop contact.
    output logic contactor_a_out, // Contactor A status, high closed.
    output logic contactor_b_out, // Contactor B status, high closed.
    output logic contact_closed_out // Process contact, high closed.
);
    // Feedback reads closed unless a drop or opening is commanded, so only commanded drops count.
    assign contactor_a_out = !drop_a_in;
    assign contactor_b_out = !drop_b_in;
    assign contact_closed_out = !open_in;
endmodule

//--- bench/tb_top.sv
// Bench for the stop trip latch, with a small model of expected outputs.
// Assumes the field model stands on the pin side of the design.
`timescale 1ns/10ps
module tb_top;
    import stl_pkg::*;
    logic mclk_in = 0; // System clock.
    logic rst_in = 1; // Reset, held at start.
    stl_mode_t cm, km, pm; // Stop mode settings.
    logic start, key, rkey, drop_a, drop_b, open_c; // Bench stimulus.
    logic ca, cb, pc, run_out, stop_cmd_out, dn, et, kt, pt; // Wires.
    logic exp_run; // Model: expected run command.
    logic [2:0] trip; // Model: expected trips, dropout key process.
    logic [31:0] seed = 32'hfedc; // Random state.
    int failures = 0, checked = 0, cycles = 0; // Counters.
    always #2 mclk_in = ~mclk_in; // A 4 ns clock.
    stl_field_model u_field (.drop_a_in(drop_a), .drop_b_in(drop_b),
        .open_in(open_c), .contactor_a_out(ca), .contactor_b_out(cb),
        .contact_closed_out(pc));
    stl_stop_trip_latch u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .contactor_stop_mode_in(cm), .front_panel_key_stop_mode_in(km),
        .process_stop_mode_in(pm), .contactor_a_closed_in(ca),
        .contactor_b_closed_in(cb), .stop_key_in(key),
        .reset_key_in(rkey), .process_contact_closed_in(pc),
        .start_req_in(start), .run_out(run_out),
        .stop_cmd_out(stop_cmd_out), .dropout_notice_out(dn),
        .emergency_trip_out(et), .key_trip_out(kt), .process_trip_out(pt));
    // Next value of the random sequence.
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Waits a number of edges, then steps off the sampling edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    // Compares all outputs with the model.
    task automatic chk(input logic note);
        logic [5:0] got, exp;
        got = {run_out, stop_cmd_out, dn, et, kt, pt};
        exp = {exp_run, ~exp_run, note, trip};
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    // Lets a random number of settled cycles pass, then compares.
    task automatic settle(input logic note);
        seed = lfsr(seed);
        cyc(4 + int'(seed[1:0]));
        chk(note);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end
    // Each source in each mode: run, stop event, retry, reset key.
    initial begin
        {start, key, rkey, drop_a, drop_b, open_c} = '0;
        // Process stop latched through reset: no false trip may follow.
        cm = STL_UNLATCHED;
        km = STL_UNLATCHED;
        pm = STL_LATCHED;
        {exp_run, trip} = '0;
        repeat (16) @(posedge mclk_in);
        #1 rst_in = 0;
        settle(0);
        for (int s = 0; s < 3; s++) begin
            for (int m = 0; m < 2; m++) begin
                seed = lfsr(seed);
                cm = stl_mode_t'(s == 0 ? m[0] : seed[4]);
                km = stl_mode_t'(s == 1 ? m[0] : seed[5]);
                pm = stl_mode_t'(s == 2 ? m[0] : seed[6]);
                start = 1;
                exp_run = 1;
                settle(0);
                start = 0;
                case (s)
                    0: {drop_a, drop_b} = seed[3] ? 2'b10 : 2'b01;
                    1: key = 1;
                    default: open_c = 1;
                endcase
                cyc(1);
                {drop_a, drop_b, key, open_c} = '0;
                exp_run = 0;
                trip = m ? 3'b100 >> s : 3'b000;
                settle(s == 0 && m == 0);
                // A dropout while stopped is no external stop.
                drop_b = 1;
                settle(s == 0 && m == 0);
                drop_b = 0;
                start = 1;
                exp_run = !m[0];
                settle(0);
                rkey = 1;
                exp_run = 1;
                trip = 0;
                cyc(4);
                chk(0);
                rkey = 0;
                start = 0;
                cyc(1);
            end
        end
        end_sim();
    end
endmodule
